// ===== shared/core_interrupt_block_defines.svh
// Register offsets, field layouts and reset values of the interrupt block.
// Included by the package and the design; definitions only.
`ifndef INTERRUPT_BLOCK_DEFINES_SVH
`define INTERRUPT_BLOCK_DEFINES_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define CH_COUNT 64
`define CH_EXT 16
`define FAST_LEVELS 2
`define NORM_LEVELS 6
`define PRIO_W 3
`define ADDR_W 8

// ----------------------------------------------------------------------
// Word index of each register (byte address = index * 4)
// ----------------------------------------------------------------------
`define REG_ENABLE_LO 8'h00
`define REG_ENABLE_HI 8'h01
`define REG_STEER_LO 8'h02
`define REG_STEER_HI 8'h03
`define REG_PEND_LO 8'h04
`define REG_PEND_HI 8'h05
`define REG_FAST_ENTRY 8'h06
`define REG_NORM_ENTRY 8'h07
`define REG_STATUS 8'h08
`define REG_MASK 8'h09
`define REG_TABLE_BASE 8'h0a
`define REG_PRIO_BASE 8'h10
`define REG_ENTRY_BASE 8'h40

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define ENTRY_VALID_BIT 31
`define STAT_FAST_BIT 0
`define STAT_NORM_BIT 1
`define PRIO_RESET 3'h0
`define NO_CH 7'h40

`endif

// ===== shared/core_interrupt_block_pkg.sv
// Types used by the interrupt block; its bench does not import them.
// Assumes the defines header sits beside it on the include path.
`include "core_interrupt_block_defines.svh"

package interrupt_block_pkg;
   typedef logic [`CH_COUNT-1:0] ch_vec_t;
   typedef logic [`PRIO_W-1:0] prio_t;
   typedef logic [6:0] ch_idx_t;
endpackage

// ===== hw/core_interrupt_controller.sv
// Interrupt block: gathers 64 channels, masks, steers, prioritises and
// presents the service routine entry address for the fast and normal lines.
// Assumes an Avalon-MM master on sys_clk; external sources are asynchronous.
//
// Notes on behaviour
// R1: Sixty-four channels, sixteen from outside pins.
// R2: Per-channel enable; disabled channel never requests.
// R3: Each channel steered to fast or normal.
// R4: Hardware picks winner among simultaneous pending.
// R5: Two fast levels, six normal levels.
// R6: Writable entry address table per channel.
// R7: Winner's service routine address in entry register.
// R8: Handler reads entry register, branches directly.
// R9: Fast and normal request outputs, any pending.
// R10: Entry register changes only when winner changes.
`timescale 1ns/10ps
`include "core_interrupt_block_defines.svh"

module core_interrupt_controller
#(
   parameter int CH_N = `CH_COUNT,
   parameter int EXT_N = `CH_EXT
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [EXT_N-1:0] ext_irq,
   input wire logic [CH_N-EXT_N-1:0] periph_irq,
   input wire logic [`ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic fast_request,
   output logic normal_request,
   output logic irq_out
);
   import interrupt_block_pkg::*;

   // ----------------------------------------------------------------------
   // Source capture
   // ----------------------------------------------------------------------
   // Pins get two flops; on-chip sources share our clock and pass straight.
   // Sources are levels: a pin pulse shorter than one clock may be lost.
   logic [EXT_N-1:0] ext_meta_q, ext_sync_q;
   logic [CH_N-1:0] raw;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_meta_q <= '0;
         ext_sync_q <= '0;
      end
      else
      begin
         ext_meta_q <= ext_irq;
         ext_sync_q <= ext_meta_q;
      end
   end

   assign raw = {periph_irq, ext_sync_q}; // R1

   // ----------------------------------------------------------------------
   // Configuration storage
   // ----------------------------------------------------------------------
   logic [CH_N-1:0] enable_q, enable_d;
   logic [CH_N-1:0] steer_q, steer_d;
   logic [`PRIO_W-1:0] prio_q [CH_N];
   logic [`PRIO_W-1:0] prio_d [CH_N];
   logic [31:0] entry_tab_q [CH_N];
   logic [31:0] entry_tab_d [CH_N];
   logic [31:0] fast_base_q, fast_base_d;
   logic [31:0] norm_base_q, norm_base_d;
   logic [1:0] stat_q, stat_d;
   logic [1:0] mask_q, mask_d;

   logic [CH_N-1:0] pend_fast, pend_norm;
   assign pend_fast = raw & enable_q & steer_q;  // R2 R3
   assign pend_norm = raw & enable_q & ~steer_q; // R2 R3

   // ----------------------------------------------------------------------
   // Priority resolution
   // ----------------------------------------------------------------------
   // Lower level wins; equal levels go to the lower channel number.
   // Fast levels are clipped to 0..1 and normal to 0..5.
   // A linear search over all channels: one long combinational path traded
   // for a small area, which is ample at this clock rate.
   function automatic prio_t clip(input prio_t p, input prio_t top);
      clip = (p > top) ? top : p;
   endfunction

   function automatic ch_idx_t pick(input logic [CH_N-1:0] pend,
      input prio_t top);
      prio_t best;
      ch_idx_t who;
      best = top;
      who = `NO_CH;
      for (int i = 0; i < CH_N; i++)
      begin
         if (pend[i] && (who == `NO_CH || clip(prio_q[i], top) < best))
         begin
            best = clip(prio_q[i], top);
            who = 7'(i);
         end
      end
      pick = who;
   endfunction

   ch_idx_t win_fast, win_norm;

   // Procedural, so that a change of a priority field alone re-runs the
   // search even while the pending vectors stay the same
   always_comb
   begin
      win_fast = pick(pend_fast, 3'(`FAST_LEVELS - 1)); // R4 R5
      win_norm = pick(pend_norm, 3'(`NORM_LEVELS - 1)); // R4 R5
   end

   // ----------------------------------------------------------------------
   // Entry registers and request lines
   // ----------------------------------------------------------------------
   ch_idx_t fwin_q, nwin_q;
   logic [31:0] fentry_q, fentry_d, nentry_q, nentry_d;
   logic fast_q, norm_q, irq_q;

   function automatic logic [31:0] entry_of(input ch_idx_t w,
      input logic [31:0] base);
      logic [31:0] e;
      e = '0;
      if (w != `NO_CH)
      begin
         e = base + entry_tab_q[w[5:0]];
         e[`ENTRY_VALID_BIT] = 1'b1;
      end
      entry_of = e;
   endfunction

   always_comb
   begin
      // Reload only on a change of winner, so a read during service is stable
      fentry_d = fentry_q;
      nentry_d = nentry_q;
      if (win_fast != fwin_q)
         fentry_d = entry_of(win_fast, fast_base_q); // R7 R10
      if (win_norm != nwin_q)
         nentry_d = entry_of(win_norm, norm_base_q); // R7 R10
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fwin_q <= `NO_CH;
         nwin_q <= `NO_CH;
         fentry_q <= '0;
         nentry_q <= '0;
         fast_q <= 1'b0;
         norm_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         fwin_q <= win_fast;
         nwin_q <= win_norm;
         fentry_q <= fentry_d;
         nentry_q <= nentry_d;
         fast_q <= |pend_fast; // R9
         norm_q <= |pend_norm; // R9
         irq_q <= |(stat_d & mask_q);
      end
   end

   assign fast_request = fast_q;
   assign normal_request = norm_q;
   assign irq_out = irq_q;

   // ----------------------------------------------------------------------
   // Avalon-MM slave
   // ----------------------------------------------------------------------
   // One wait cycle per access: waitrequest drops in the cycle after the
   // request appears. Read data is latched at that first edge, so it already
   // stands when the master samples waitrequest low; a write lands at the
   // second edge, the one at which the master completes the access.
   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] wmask;
   logic [31:0] prio_word;

   always_comb
   begin
      for (int b = 0; b < 4; b++)
         wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
      // A priority word replaces all eight fields; disabled lanes give 0
      prio_word = avs_writedata & wmask;
   end

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   // Shared by the read and the write path; anything outside these windows
   // and the named words reads zero and ignores writes.
   function automatic logic is_entry(input logic [`ADDR_W-1:0] a);
      is_entry = (a >= `REG_ENTRY_BASE) && (a < `REG_ENTRY_BASE + 8'(CH_N));
   endfunction

   function automatic logic is_prio(input logic [`ADDR_W-1:0] a);
      is_prio = (a >= `REG_PRIO_BASE) && (a < `REG_PRIO_BASE + 8'(CH_N / 8));
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old);
      merge = (old & ~wmask) | (avs_writedata & wmask);
   endfunction

   // ----------------------------------------------------------------------
   // Register file and sticky status
   // ----------------------------------------------------------------------
   // Event edges: a request line rising sets the sticky status bit
   logic [1:0] ev;
   assign ev = {(|pend_norm) & ~norm_q, (|pend_fast) & ~fast_q};

   always_comb
   begin
      enable_d = enable_q;
      steer_d = steer_q;
      fast_base_d = fast_base_q;
      norm_base_d = norm_base_q;
      mask_d = mask_q;
      stat_d = stat_q;
      prio_d = prio_q;
      entry_tab_d = entry_tab_q;
      wait_d = (avs_read | avs_write) & ~wait_q;
      rdata_d = rdata_q;
      if (avs_write && wait_q)
      begin
         case (avs_address)
            `REG_ENABLE_LO: enable_d[31:0] = merge(enable_q[31:0]); // R2
            `REG_ENABLE_HI: enable_d[63:32] = merge(enable_q[63:32]);
            `REG_STEER_LO: steer_d[31:0] = merge(steer_q[31:0]); // R3
            `REG_STEER_HI: steer_d[63:32] = merge(steer_q[63:32]);
            `REG_TABLE_BASE: fast_base_d = merge(fast_base_q); // R6
            `REG_TABLE_BASE + 8'h01: norm_base_d = merge(norm_base_q);
            `REG_MASK: mask_d = 2'(merge({30'h0, mask_q}));
            default:
            begin
               if (is_entry(avs_address))
                  entry_tab_d[avs_address[5:0]] =
                     merge(entry_tab_q[avs_address[5:0]]); // R6
               else if (is_prio(avs_address))
                  for (int k = 0; k < 8; k++)
                     prio_d[{avs_address[2:0], 3'(k)}] =
                        prio_word[k*4 +: 3]; // R5
            end
         endcase
      end
      // Captured at the first edge so the data stand at the completing one
      if (avs_read && !wait_q)
      begin
         rdata_d = '0;
         case (avs_address)
            `REG_ENABLE_LO: rdata_d = enable_q[31:0];
            `REG_ENABLE_HI: rdata_d = enable_q[63:32];
            `REG_STEER_LO: rdata_d = steer_q[31:0];
            `REG_STEER_HI: rdata_d = steer_q[63:32];
            `REG_PEND_LO: rdata_d = raw[31:0];
            `REG_PEND_HI: rdata_d = raw[63:32];
            `REG_FAST_ENTRY: rdata_d = fentry_q; // R7 R8
            `REG_NORM_ENTRY: rdata_d = nentry_q; // R7 R8
            `REG_STATUS:
            begin
               rdata_d = {30'h0, stat_q};
               stat_d = 2'b00;
            end
            `REG_MASK: rdata_d = {30'h0, mask_q};
            `REG_TABLE_BASE: rdata_d = fast_base_q;
            `REG_TABLE_BASE + 8'h01: rdata_d = norm_base_q;
            default:
            begin
               if (is_entry(avs_address))
                  rdata_d = entry_tab_q[avs_address[5:0]];
               else if (is_prio(avs_address))
                  for (int k = 0; k < 8; k++)
                     rdata_d[k*4 +: 3] = prio_q[{avs_address[2:0], 3'(k)}];
            end
         endcase
      end
      // Set wins over the clear by read
      stat_d = stat_d | ev;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         enable_q <= '0;
         steer_q <= '0;
         fast_base_q <= '0;
         norm_base_q <= '0;
         mask_q <= '0;
         stat_q <= '0;
         wait_q <= 1'b0;
         rdata_q <= '0;
         for (int i = 0; i < CH_N; i++)
         begin
            prio_q[i] <= `PRIO_RESET;
            entry_tab_q[i] <= '0;
         end
      end
      else
      begin
         enable_q <= enable_d;
         steer_q <= steer_d;
         fast_base_q <= fast_base_d;
         norm_base_q <= norm_base_d;
         mask_q <= mask_d;
         stat_q <= stat_d;
         wait_q <= wait_d;
         rdata_q <= rdata_d;
         prio_q <= prio_d;
         entry_tab_q <= entry_tab_d;
      end
   end

   // ----------------------------------------------------------------------
   // Handshake
   // ----------------------------------------------------------------------
   // Waitrequest low exactly in the second cycle of each access; a master
   // that keeps its request up after completion starts a new access.
   logic wr_q;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         wr_q <= 1'b1;
      else
         wr_q <= ~((avs_read | avs_write) & ~wait_q);
   end

   assign avs_waitrequest = wr_q;
   assign avs_readdata = rdata_q;
endmodule

// ===== testbench/core_interrupt_block_checker.sv
// Port checks of the interrupt block.
// Bound to every instance; sees its top ports only.
`timescale 1ns/10ps
`include "core_interrupt_block_defines.svh"
module interrupt_block_checker
#(
   parameter int CH_N = `CH_COUNT,
   parameter int EXT_N = `CH_EXT
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [EXT_N-1:0] ext_irq,
   input wire logic [CH_N-EXT_N-1:0] periph_irq,
   input wire logic [`ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic fast_request,
   input wire logic normal_request
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_answer;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   // External sources cross two sync flops, so four quiet edges cover all
   sequence s_quiet;
      (periph_irq == '0 && ext_irq == '0) [*4];
   endsequence
   property p_latency; $rose(avs_read || avs_write) |-> s_answer; endproperty
   a_latency: assert property (p_latency)
      else $error("bus answer late");
   property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_one: assert property (p_one)
      else $error("waitrequest low too long");
   property p_cause; $fell(avs_waitrequest) |-> avs_read || avs_write;
   endproperty
   a_cause: assert property (p_cause)
      else $error("answer without request");
   property p_quiet; s_quiet |=> !fast_request && !normal_request;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("request with no source");
   property p_fast;
      $rose(fast_request) |-> $past(|periph_irq) || $past(|ext_irq, 3);
   endproperty
   a_fast: assert property (p_fast)
      else $error("fast request without cause");
   property p_norm;
      $rose(normal_request) |-> $past(|periph_irq) || $past(|ext_irq, 3);
   endproperty
   a_norm: assert property (p_norm)
      else $error("normal request without cause");
   property p_hole;
      avs_read && !avs_waitrequest && avs_address >= 8'h80
         |-> avs_readdata == '0;
   endproperty
   a_hole: assert property (p_hole)
      else $error("unmapped read not zero");
   property p_hold; !avs_read |=> $stable(avs_readdata); endproperty
   a_hold: assert property (p_hold)
      else $error("read data moved");
endmodule
bind core_interrupt_controller interrupt_block_checker
   #(.CH_N(CH_N), .EXT_N(EXT_N))
   chk (.sys_clk(sys_clk), .rst_n(rst_n), .ext_irq(ext_irq),
   .periph_irq(periph_irq), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .fast_request(fast_request),
   .normal_request(normal_request));

// ===== testbench/core_side_model.sv
// Core-side model: picks which entry word the handler fetches.
// Assumes the bench does the fetch when a take flag is set.
`timescale 1ns/10ps
module core_side_model
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic fast_request,
   input wire logic normal_request,
   output logic take_fast,
   output logic take_norm
);
   // Fast line outranks normal, as in the core's own entry order
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         {take_fast, take_norm} <= 2'b00;
      else
         {take_fast, take_norm} <=
            {fast_request, normal_request & ~fast_request};
endmodule

// ===== testbench/tb.sv
// Self-checking bench of the interrupt block.
// Assumes the checker binds itself to the block.
`timescale 1ns/10ps
`include "core_interrupt_block_defines.svh"
module tb;
   logic sys_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
   logic [15:0] ext_irq = '0;
   logic [47:0] periph_irq = '0;
   logic [7:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata, q, e;
   logic avs_waitrequest, fast_request, normal_request, irq_out, tf, tn;
   int mismatches = 0, checks = 0;
   always #25 sys_clk = ~sys_clk;
   core_interrupt_controller uut (.sys_clk(sys_clk), .rst_n(rst_n),
      .ext_irq(ext_irq), .periph_irq(periph_irq), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .fast_request(fast_request), .normal_request(normal_request),
      .irq_out(irq_out));
   core_side_model core (.sys_clk(sys_clk), .rst_n(rst_n), .take_fast(tf),
      .fast_request(fast_request), .normal_request(normal_request),
      .take_norm(tn));
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
      int n;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      for (n = 0; n < 20 && avs_waitrequest !== 1'b0; n++)
         @(posedge sys_clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n == 20)
      begin
         mismatches++;
         final_report();
      end
   endtask
   task automatic src(int ch, logic v);
      if (ch < 16)
         ext_irq[ch] <= v;
      else
         periph_irq[ch-16] <= v;
   endtask
   // Whole words are written, so other channels of the word drop out
   task automatic route(int ch, logic on, logic f);
      bus(1, 8'(ch / 32), on ? 32'h1 << (ch % 32) : '0);
      bus(1, 8'(2 + ch / 32), f ? 32'h1 << (ch % 32) : '0);
   endtask
   function automatic int winner(int pa, int pb, logic f);
      int lim = f ? 1 : 5;
      return ((pb > lim ? lim : pb) < (pa > lim ? lim : pa)) ? 40 : 20;
   endfunction
   function automatic logic [31:0] entry(int i, int w);
      return (32'h100 * (i + 1) + (w == 20 ? 32'h24 : 32'h48)) | 32'h80000000;
   endfunction
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      final_report();
   end
   initial
   begin
      int ch, pa, pb, w;
      logic f;
      void'($urandom(71));
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      bus(0, `REG_ENABLE_LO, 0);
      cmp("enable", 0, q);
      bus(0, 8'h80, 0);
      cmp("unmapped", 0, q);
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         ch = i == 0 ? 63 : i == 1 ? 0 : $urandom % 64;
         f = 1'($urandom % 2);
         route(ch, 1, f);
         src(ch, 1);
         repeat (5) @(posedge sys_clk);
         cmp("fast", f, fast_request);
         cmp("normal", !f, normal_request);
         route(ch, 0, f);
         repeat (5) @(posedge sys_clk);
         cmp("off", 0, {fast_request, normal_request});
         src(ch, 0);
      end
      $display("test steering done");
      for (int i = 0; i < 4; i++)
      begin
         f = i[0];
         pa = i < 2 ? 7 : $urandom % 8;
         pb = i < 2 ? 5 : $urandom % 8;
         w = winner(pa, pb, f);
         bus(1, 8'h12, 32'(pa) << 16);
         bus(1, 8'h15, 32'(pb));
         bus(1, f ? `REG_TABLE_BASE : 8'h0b, 32'h100 * (i + 1));
         bus(1, `REG_ENTRY_BASE + 8'd20, 32'h24);
         bus(1, `REG_ENTRY_BASE + 8'd40, 32'h48);
         bus(1, `REG_MASK, i == 2 ? 0 : 3);
         route(20, 1, f);
         route(40, 1, f);
         bus(0, `REG_STATUS, 0);
         src(20, 1);
         src(40, 1);
         repeat (5) @(posedge sys_clk);
         cmp("take", f, tf);
         e = tf ? `REG_FAST_ENTRY : `REG_NORM_ENTRY;
         bus(0, e[7:0], 0);
         cmp("entry", entry(i, w), q);
         bus(0, e[7:0], 0);
         cmp("entry again", entry(i, w), q);
         cmp("irq", i != 2, irq_out);
         bus(0, `REG_STATUS, 0);
         cmp("status", f ? 1 : 2, q);
         route(w, 0, f);
         repeat (5) @(posedge sys_clk);
         bus(0, e[7:0], 0);
         cmp("entry next", entry(i, 60 - w), q);
         src(20, 0);
         src(40, 0);
         repeat (5) @(posedge sys_clk);
         bus(0, `REG_STATUS, 0);
         cmp("irq clear", 0, irq_out);
      end
      $display("test priority done");
      final_report();
   end
endmodule
